/* mdsd_regs.sv */
// register bank for channel spacing and deviation, AXI4-Lite slave
// assumes one AXI4-Lite master; one write and one read in flight at most
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
module mdsd_regs
  import mdsd_pkg::*;
(
  input  wire logic                MCLK,            // 50 MHz clock
  input  wire logic                RESETN,          // async reset, low
  input  wire logic [ADDR_W-1:0]   S_AXI_AWADDR,    // write address
  input  wire logic [2:0]          S_AXI_AWPROT,    // unused
  input  wire logic                S_AXI_AWVALID,   // write address valid
  output logic                     S_AXI_AWREADY,   // write address ready
  input  wire logic [31:0]         S_AXI_WDATA,     // write data
  input  wire logic [3:0]          S_AXI_WSTRB,     // byte strobes
  input  wire logic                S_AXI_WVALID,    // write data valid
  output logic                     S_AXI_WREADY,    // write data ready
  output logic [1:0]               S_AXI_BRESP,     // write response
  output logic                     S_AXI_BVALID,    // write response valid
  input  wire logic                S_AXI_BREADY,    // write response ready
  input  wire logic [ADDR_W-1:0]   S_AXI_ARADDR,    // read address
  input  wire logic [2:0]          S_AXI_ARPROT,    // unused
  input  wire logic                S_AXI_ARVALID,   // read address valid
  output logic                     S_AXI_ARREADY,   // read address ready
  output logic [31:0]              S_AXI_RDATA,     // read data
  output logic [1:0]               S_AXI_RRESP,     // read response
  output logic                     S_AXI_RVALID,    // read data valid
  input  wire logic                S_AXI_RREADY,    // read data ready
  input  wire logic                TX_DATA_BIT,     // bit now sent
  output logic [SPC_W-1:0]         CHANNEL_NUMBER_SPACING,    // spacing, fref/2^18
  output logic [FREQ_W-1:0]        OP_FREQ,         // frequency, fref/2^18
  output logic [DEV_W-1:0]         DEVIATION,       // deviation, fref/2^17
  output logic signed [DEV_W:0]    TX_FREQ_OFFSET,  // signed carrier offset
  output logic [3:0]               MSK_PHASE_FRAC,  // eighths of a symbol
  output logic                     MSK_PHASE_NEG,   // high: -90 deg step
  output logic [DEV_W-1:0]         RX_EXP_DEV       // expected rx deviation
);
  typedef struct packed {
    mdsd_wst_e         wst;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp;
    mdsd_rst_e         rst;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [7:0]        spc_m;
    logic [2:0]        dev_e;
    logic [2:0]        dev_m;
    logic [1:0]        spc_e;
    logic [7:0]        channel_number;
    logic [2:0]        modsel;
    logic              rx;
    logic [31:0]       base;
  } mdsd_top_s;

  mdsd_top_s q, d;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        wr_go;
  logic [SPC_W-1:0]  spacing;
  logic [FREQ_W-1:0] freq;
  logic [DEV_W-1:0]  dev;

  mdsd_cfg_if cfg ();

  // read mux; unused bits of narrow registers read as zero
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    case (S_AXI_ARADDR)
      A_SPC_MANT: begin
        rd_word[7:0] = q.spc_m;
      end
      A_DEVIATION: begin
        rd_word[DEV_E_LO +: 3] = q.dev_e;
        rd_word[DEV_M_LO +: 3] = q.dev_m;
      end
      A_RADIO_CTRL: begin
        rd_word[CTRL_SPC_E +: 2] = q.spc_e;
        rd_word[CTRL_CHANNEL_NUMBER +: 8]  = q.channel_number;
        rd_word[CTRL_MOD +: 3]   = q.modsel;
        rd_word[CTRL_RX]         = q.rx;
      end
      A_BASE_FREQ: begin
        rd_word = q.base;
      end
      A_SPACING_ST: begin
        rd_word[SPC_W-1:0] = spacing;
      end
      A_FREQ_ST: begin
        rd_word = freq;
      end
      A_DEV_ST: begin
        rd_word[DEV_W-1:0] = dev;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  assign wr_go = (q.wst == WS_COLLECT) && q.aw_got && q.w_got;

  always_comb begin
    d = q;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      d.aw_got = 1'b1;
      d.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      d.w_got = 1'b1;
      d.wdata = S_AXI_WDATA;
      d.wstrb = S_AXI_WSTRB;
    end
    if (wr_go) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.wst    = WS_RESP;
      d.bresp  = RESP_OKAY;
      case (q.awaddr)
        A_SPC_MANT: begin
          if (q.wstrb[0]) begin
            d.spc_m = q.wdata[7:0];
          end
        end
        A_DEVIATION: begin
          // bits 7 and 3 have no storage, writes there are dropped
          if (q.wstrb[0]) begin
            d.dev_e = q.wdata[DEV_E_LO +: 3];
            d.dev_m = q.wdata[DEV_M_LO +: 3];
          end
        end
        A_RADIO_CTRL: begin
          if (q.wstrb[0]) begin
            d.spc_e = q.wdata[CTRL_SPC_E +: 2];
          end
          if (q.wstrb[1]) begin
            d.channel_number = q.wdata[CTRL_CHANNEL_NUMBER +: 8];
          end
          if (q.wstrb[2]) begin
            d.modsel = q.wdata[CTRL_MOD +: 3];
          end
          if (q.wstrb[3]) begin
            d.rx = q.wdata[CTRL_RX];
          end
        end
        A_BASE_FREQ: begin
          for (int i = 0; i < 4; i++) begin
            if (q.wstrb[i]) begin
              d.base[8*i +: 8] = q.wdata[8*i +: 8];
            end
          end
        end
        A_SPACING_ST, A_FREQ_ST, A_DEV_ST: begin
          d.bresp = RESP_OKAY;
        end
        default: begin
          d.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (q.wst == WS_RESP && S_AXI_BREADY) begin
      d.wst = WS_COLLECT;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      d.rst   = RS_DATA;
      d.rdata = rd_word;
      d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (q.rst == RS_DATA && S_AXI_RREADY) begin
      d.rst = RS_IDLE;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      q        <= '0;
      q.wst    <= WS_COLLECT;
      q.rst    <= RS_IDLE;
      q.bresp  <= RESP_OKAY;
      q.rresp  <= RESP_OKAY;
      q.spc_m  <= RST_SPC_MANT;
      q.dev_e  <= RST_DEV_E;
      q.dev_m  <= RST_DEV_M;
      q.spc_e  <= RST_SPC_E;
      q.channel_number   <= RST_CHANNEL_NUMBER;
      q.modsel <= RST_MOD;
      q.rx     <= 1'b0;
      q.base   <= RST_BASE;
    end else begin
      q <= d;
    end
  end

  // a held address waits until the write response is taken
  assign S_AXI_AWREADY = (q.wst == WS_COLLECT) && !q.aw_got;
  assign S_AXI_WREADY  = (q.wst == WS_COLLECT) && !q.w_got;
  assign S_AXI_BVALID  = (q.wst == WS_RESP);
  assign S_AXI_BRESP   = q.bresp;
  assign S_AXI_ARREADY = (q.rst == RS_IDLE);
  assign S_AXI_RVALID  = (q.rst == RS_DATA);
  assign S_AXI_RDATA   = q.rdata;
  assign S_AXI_RRESP   = q.rresp;

  assign cfg.spc_m  = q.spc_m;
  assign cfg.spc_e  = q.spc_e;
  assign cfg.channel_number   = q.channel_number;
  assign cfg.base   = q.base;
  assign cfg.dev_e  = q.dev_e;
  assign cfg.dev_m  = q.dev_m;
  assign cfg.modsel = q.modsel;
  assign cfg.rx     = q.rx;

  mdsd_spacing u_spacing (
    .clk     (MCLK),
    .rst_n   (RESETN),
    .cfg     (cfg),
    .spacing (spacing),
    .freq    (freq)
  );

  mdsd_deviation u_deviation (
    .clk      (MCLK),
    .rst_n    (RESETN),
    .cfg      (cfg),
    .tx_bit   (TX_DATA_BIT),
    .dev      (dev),
    .tx_off   (TX_FREQ_OFFSET),
    .msk_frac (MSK_PHASE_FRAC),
    .msk_neg  (MSK_PHASE_NEG),
    .rx_dev   (RX_EXP_DEV)
  );

  assign CHANNEL_NUMBER_SPACING = spacing;
  assign OP_FREQ      = freq;
  assign DEVIATION    = dev;

  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);

  a_mant_write: assert property (wr_go && q.awaddr == A_SPC_MANT && q.wstrb[0] |=>
    q.spc_m == $past(q.wdata[7:0]) && S_AXI_BVALID && S_AXI_BRESP == RESP_OKAY)
    else $error("spacing mantissa write lost");
  a_mant_read: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
    S_AXI_ARADDR == A_SPC_MANT |=> S_AXI_RVALID && S_AXI_RDATA == {24'h000000, $past(q.spc_m)})
    else $error("spacing mantissa readback wrong");
  a_dev_write: assert property (wr_go && q.awaddr == A_DEVIATION && q.wstrb[0] |=>
    q.dev_e == $past(q.wdata[6:4]) && q.dev_m == $past(q.wdata[2:0]))
    else $error("deviation fields not written");
  a_dev_unused: assert property (S_AXI_ARVALID && S_AXI_ARREADY &&
    S_AXI_ARADDR == A_DEVIATION |=> S_AXI_RDATA[31:7] == 25'h0 && !S_AXI_RDATA[3])
    else $error("deviation unused bits not zero");
  a_resp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_write_answer: assert property (wr_go |=> S_AXI_BVALID)
    else $error("write response late");
  a_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
endmodule

/* mdsd_pkg.sv */
// constants, types and register map of the modem spacing/deviation bank
// assumes one 50 MHz clock and an AXI4-Lite master with 32-bit data
package mdsd_pkg;
  localparam int ADDR_W = 18;
  localparam int SPC_W  = 12;
  localparam int DEV_W  = 11;
  localparam int FREQ_W = 32;
  // printed offsets are word indices; byte address is four times
  localparam logic [15:0] IDX_SPC_MANT  = 16'hDF10;
  localparam logic [15:0] IDX_DEVIATION = 16'hDF11;
  localparam logic [ADDR_W-1:0] A_SPC_MANT   = {IDX_SPC_MANT, 2'b00};
  localparam logic [ADDR_W-1:0] A_DEVIATION  = {IDX_DEVIATION, 2'b00};
  localparam logic [ADDR_W-1:0] A_RADIO_CTRL = 18'h00000;
  localparam logic [ADDR_W-1:0] A_BASE_FREQ  = 18'h00004;
  localparam logic [ADDR_W-1:0] A_SPACING_ST = 18'h00008;
  localparam logic [ADDR_W-1:0] A_FREQ_ST    = 18'h0000C;
  localparam logic [ADDR_W-1:0] A_DEV_ST     = 18'h00010;
  localparam int DEV_E_LO    = 4;
  localparam int DEV_M_LO    = 0;
  localparam int CTRL_SPC_E  = 0;
  localparam int CTRL_CHANNEL_NUMBER   = 8;
  localparam int CTRL_MOD    = 16;
  localparam int CTRL_RX     = 24;
  localparam logic [7:0]  RST_SPC_MANT = 8'hF8;
  localparam logic [2:0]  RST_DEV_E    = 3'h4;
  localparam logic [2:0]  RST_DEV_M    = 3'h7;
  localparam logic [1:0]  RST_SPC_E    = 2'h2;
  localparam logic [7:0]  RST_CHANNEL_NUMBER     = 8'h00;
  localparam logic [2:0]  RST_MOD      = 3'h0;
  localparam logic [31:0] RST_BASE     = 32'h00000000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  typedef enum logic [2:0] {
    MOD_FSK2 = 3'b000,
    MOD_GFSK = 3'b001,
    MOD_ASK  = 3'b011,
    MOD_MSK  = 3'b111
  } mdsd_mod_e;
  typedef enum logic [0:0] {
    WS_COLLECT = 1'b0,
    WS_RESP    = 1'b1
  } mdsd_wst_e;
  typedef enum logic [0:0] {
    RS_IDLE = 1'b0,
    RS_DATA = 1'b1
  } mdsd_rst_e;
endpackage

/* mdsd_cfg_if.sv */
// configuration fields passed from the register file to the datapath
// assumes a single clock domain; fields change only on bus writes
`timescale 1ns/10ps
interface mdsd_cfg_if;
  logic [7:0]  spc_m;
  logic [1:0]  spc_e;
  logic [7:0]  channel_number;
  logic [31:0] base;
  logic [2:0]  dev_e;
  logic [2:0]  dev_m;
  logic [2:0]  modsel;
  logic        rx;
  modport src (output spc_m, spc_e, channel_number, base, dev_e, dev_m, modsel, rx);
  modport snk (input  spc_m, spc_e, channel_number, base, dev_e, dev_m, modsel, rx);
endinterface

/* mdsd_spacing.sv */
// channel spacing and operating frequency, in units of fref/2^18
// assumes configuration fields from the register file on the same clock
`timescale 1ns/10ps
module mdsd_spacing
  import mdsd_pkg::*;
(
  input  wire logic              clk,     // system clock
  input  wire logic              rst_n,   // async reset, low
  mdsd_cfg_if.snk                cfg,     // configuration fields
  output logic [SPC_W-1:0]       spacing, // channel spacing
  output logic [FREQ_W-1:0]      freq     // operating frequency
);
  typedef struct packed {
    logic [SPC_W-1:0]  spacing;
    logic [FREQ_W-1:0] freq;
  } mdsd_spc_s;
  mdsd_spc_s q, d;
  logic [19:0] channel_number_off;

  always_comb begin
    d = q;
    d.spacing = SPC_W'({1'b1, cfg.spc_m}) << cfg.spc_e;
    channel_number_off  = q.spacing * cfg.channel_number;
    d.freq    = cfg.base + FREQ_W'(channel_number_off);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign spacing = q.spacing;
  assign freq    = q.freq;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // first edge after release still shows the cleared register
  a_spacing_calc: assert property ($past(rst_n) && $stable(cfg.spc_m) &&
    $stable(cfg.spc_e) |-> spacing == (12'd256 + cfg.spc_m) * (12'd1 << cfg.spc_e))
    else $error("channel spacing wrong");
  a_freq_sum: assert property ($stable(cfg.channel_number) && $stable(cfg.base) |=>
    freq == $past(cfg.base) + ({20'h0, $past(spacing)} * {24'h0, $past(cfg.channel_number)}))
    else $error("operating frequency wrong");
endmodule

/* mdsd_deviation.sv */
// deviation use per modulation and direction, units of fref/2^17
// assumes the data bit comes from datapath logic on the same clock
`timescale 1ns/10ps
module mdsd_deviation
  import mdsd_pkg::*;
(
  input  wire logic            clk,      // system clock
  input  wire logic            rst_n,    // async reset, low
  mdsd_cfg_if.snk              cfg,      // configuration fields
  input  wire logic            tx_bit,   // bit being sent
  output logic [DEV_W-1:0]     dev,      // tx deviation magnitude
  output logic signed [DEV_W:0] tx_off,  // carrier offset
  output logic [3:0]           msk_frac, // phase change eighths
  output logic                 msk_neg,  // high for -90 deg
  output logic [DEV_W-1:0]     rx_dev    // expected rx deviation
);
  typedef struct packed {
    logic [DEV_W-1:0] dev;
    logic [DEV_W:0]   off;
    logic [3:0]       frac;
    logic             neg;
    logic [DEV_W-1:0] rxd;
  } mdsd_dev_s;
  mdsd_dev_s q, d;
  logic fsk_mod;
  logic fsk_tx;
  logic msk_tx;

  always_comb begin
    d       = q;
    fsk_mod = (cfg.modsel == MOD_FSK2) || (cfg.modsel == MOD_GFSK);
    fsk_tx  = !cfg.rx && fsk_mod;
    msk_tx  = !cfg.rx && (cfg.modsel == MOD_MSK);
    d.dev   = DEV_W'({1'b1, cfg.dev_m}) << cfg.dev_e;
    d.off   = '0;
    d.frac  = '0;
    d.neg   = 1'b0;
    d.rxd   = '0;
    if (fsk_tx) begin
      d.off = tx_bit ? {1'b0, d.dev} : -{1'b0, d.dev};
    end
    if (msk_tx) begin
      d.frac = {1'b0, cfg.dev_m} + 4'h1;
      d.neg  = tx_bit;
    end
    if (cfg.rx && fsk_mod) begin
      d.rxd = d.dev;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dev      = q.dev;
  assign tx_off   = q.off;
  assign msk_frac = q.frac;
  assign msk_neg  = q.neg;
  assign rx_dev   = q.rxd;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_dev_calc: assert property ($past(rst_n) |=>
    dev == (11'd8 + $past(cfg.dev_m)) * (11'd1 << $past(cfg.dev_e)))
    else $error("deviation magnitude wrong");
  a_fsk_sign: assert property (!cfg.rx && cfg.modsel == MOD_GFSK |=>
    tx_off == ($past(tx_bit) ? $signed({1'b0, dev}) : -$signed({1'b0, dev})))
    else $error("fsk offset sign wrong");
  a_msk_phase: assert property (!cfg.rx && cfg.modsel == MOD_MSK |=>
    msk_frac == $past(cfg.dev_m) + 4'h1 && msk_neg == $past(tx_bit) && tx_off == 0)
    else $error("msk phase setting wrong");
  a_ask_ignore: assert property ((cfg.modsel == MOD_ASK ||
    (cfg.rx && cfg.modsel == MOD_MSK)) |=> tx_off == 0 && msk_frac == 0 && rx_dev == 0)
    else $error("deviation used where ignored");
  a_rx_expect: assert property (cfg.rx && cfg.modsel == MOD_FSK2 |=>
    rx_dev == dev && tx_off == 0)
    else $error("rx expected deviation wrong");
endmodule

/* modem_spacing_deviation_regs_bench.sv */
// self-checking bench for the spacing/deviation register bank
// assumes mdsd_regs as top, driven over AXI4-Lite, one 50 MHz clock
`timescale 1ns/10ps
module modem_spacing_deviation_regs_bench;
  import mdsd_pkg::*;
  logic                mclk    = 1'b0;
  logic                resetn  = 1'b0;
  logic [ADDR_W-1:0]   awaddr  = '0;
  logic [ADDR_W-1:0]   araddr  = '0;
  logic                awvalid = 1'b0;
  logic                wvalid  = 1'b0;
  logic                bready  = 1'b0;
  logic                arvalid = 1'b0;
  logic                rready  = 1'b0;
  logic                tx_bit  = 1'b0;
  logic [31:0]         wdata   = '0;
  logic [3:0]          wstrb   = '0;
  logic                awready, wready, bvalid, arready, rvalid, msk_neg;
  logic [1:0]          bresp, rresp;
  logic [31:0]         rdata, op_freq;
  logic [SPC_W-1:0]    spacing;
  logic [DEV_W-1:0]    dev, rx_dev;
  logic signed [DEV_W:0] tx_off;
  logic [3:0]          msk_frac;
  int                  failures = 0;
  int                  checks   = 0;
  int                  lag      = 0;  // edges before bready/rready rise

  always #10 mclk = ~mclk;

  mdsd_regs uut (
    .MCLK(mclk), .RESETN(resetn),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .TX_DATA_BIT(tx_bit), .CHANNEL_NUMBER_SPACING(spacing),
    .OP_FREQ(op_freq), .DEVIATION(dev), .TX_FREQ_OFFSET(tx_off),
    .MSK_PHASE_FRAC(msk_frac), .MSK_PHASE_NEG(msk_neg), .RX_EXP_DEV(rx_dev)
  );

  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tmo;
    failures++;
    $display("unexpected at %0t: bus answer timed out", $time);
    end_sim;
  endtask

  // starts one edge late so a previous release never meets a new request
  task automatic w(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                   input logic [3:0] s, input logic [1:0] er);
    bit done;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= (lag == 0);
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready) begin
        chk({30'h0, bresp}, {30'h0, er}, "bresp");
        bready <= 1'b0;
        done = 1'b1;
      end else if (n + 1 >= lag) begin
        bready <= 1'b1;
      end
    end
    if (!done) tmo;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit done;
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= (lag == 0);
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready) begin
        chk(rdata, ed, "rdata");
        chk({30'h0, rresp}, {30'h0, er}, "rresp");
        rready <= 1'b0;
        done = 1'b1;
      end else if (n + 1 >= lag) begin
        rready <= 1'b1;
      end
    end
    if (!done) tmo;
  endtask

  // frequency output lags a register write by two edges; three leaves margin
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  function automatic logic [31:0] sp(input logic [7:0] m, input logic [1:0] e);
    return (32'd256 + m) << e;
  endfunction

  function automatic logic [31:0] dv(input logic [2:0] m, input logic [2:0] e);
    return (32'd8 + m) << e;
  endfunction

  initial begin
    logic [7:0]  mv [3];
    logic [2:0]  mods [5];
    logic [7:0]  ch;
    logic [11:0] eo;
    bit          fsk, mt;
    mv   = '{8'h00, 8'h7F, 8'hFF};
    mods = '{MOD_FSK2, MOD_GFSK, MOD_ASK, MOD_MSK, 3'b010};
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    rd(A_SPC_MANT, 32'h000000F8, RESP_OKAY);
    rd(A_DEVIATION, 32'h00000047, RESP_OKAY);
    settle;
    chk(32'(spacing), sp(8'hF8, 2'h2), "spacing");
    chk(32'(dev), dv(3'h7, 3'h4), "deviation");
    w(A_BASE_FREQ, 32'h12345678, 4'hF, RESP_OKAY);
    rd(A_BASE_FREQ, 32'h12345678, RESP_OKAY);
    for (int e = 0; e < 4; e++) begin
      // widest channel number at the largest exponent
      ch = (e == 3) ? 8'hFF : 8'h03;
      for (int k = 0; k < 3; k++) begin
        w(A_RADIO_CTRL, {16'h0, ch, 6'h0, e[1:0]}, 4'hF, RESP_OKAY);
        w(A_SPC_MANT, {24'h0, mv[k]}, 4'hF, RESP_OKAY);
        rd(A_SPC_MANT, {24'h0, mv[k]}, RESP_OKAY);
        settle;
        chk(32'(spacing), sp(mv[k], e[1:0]), "spacing");
        chk(op_freq, 32'h12345678 + sp(mv[k], e[1:0]) * {24'h0, ch}, "freq");
        rd(A_SPACING_ST, sp(mv[k], e[1:0]), RESP_OKAY);
        rd(A_FREQ_ST, 32'h12345678 + sp(mv[k], e[1:0]) * {24'h0, ch}, RESP_OKAY);
      end
    end
    // upper lanes only: an 8-bit register must keep its value
    w(A_SPC_MANT, 32'h00000011, 4'hE, RESP_OKAY);
    rd(A_SPC_MANT, 32'h000000FF, RESP_OKAY);
    // slow master: response and read data must stand until taken
    lag = 3;
    w(A_SPC_MANT, 32'h000000A5, 4'h1, RESP_OKAY);
    rd(A_SPC_MANT, 32'h000000A5, RESP_OKAY);
    lag = 0;
    for (int e = 0; e < 8; e++) begin
      w(A_DEVIATION, {24'h0, 1'b1, e[2:0], 1'b1, 3'(7 - e)}, 4'hF, RESP_OKAY);
      rd(A_DEVIATION, {24'h0, 1'b0, e[2:0], 1'b0, 3'(7 - e)}, RESP_OKAY);
      settle;
      chk(32'(dev), dv(3'(7 - e), e[2:0]), "deviation");
    end
    w(A_DEVIATION, 32'h00000035, 4'hF, RESP_OKAY);
    rd(A_DEV_ST, 32'd104, RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      for (int rx = 0; rx < 2; rx++) begin
        for (int b = 0; b < 2; b++) begin
          w(A_RADIO_CTRL, {7'h0, rx[0], 5'h0, mods[i], 8'h03, 8'h01}, 4'hF, RESP_OKAY);
          tx_bit <= b[0];
          settle;
          fsk = (mods[i] == MOD_FSK2) || (mods[i] == MOD_GFSK);
          mt  = (rx == 0) && (mods[i] == MOD_MSK);
          eo  = (fsk && rx == 0) ? (b[0] ? 12'd104 : -12'd104) : 12'h000;
          chk({20'h0, tx_off}, {20'h0, eo}, "tx offset");
          chk({28'h0, msk_frac}, mt ? 32'd6 : 32'd0, "msk fraction");
          chk({31'h0, msk_neg}, mt ? 32'(b) : 32'd0, "msk sign");
          chk(32'(rx_dev), (fsk && rx == 1) ? 32'd104 : 32'd0, "rx deviation");
        end
      end
    end
    w(A_DEV_ST, 32'h00000000, 4'hF, RESP_OKAY);
    rd(A_DEV_ST, 32'd104, RESP_OKAY);
    rd(18'h00100, 32'h0, RESP_SLVERR);
    w(18'h00100, 32'h1, 4'hF, RESP_SLVERR);
    rd(A_SPC_MANT + 18'h1, 32'h0, RESP_SLVERR);
    // second reset in mid-run brings the documented values back
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rd(A_SPC_MANT, 32'h000000F8, RESP_OKAY);
    rd(A_DEVIATION, 32'h00000047, RESP_OKAY);
    rd(A_RADIO_CTRL, 32'h00000002, RESP_OKAY);
    rd(A_BASE_FREQ, 32'h00000000, RESP_OKAY);
    settle;
    chk(32'(spacing), sp(8'hF8, 2'h2), "spacing");
    chk(32'(dev), dv(3'h7, 3'h4), "deviation");
    end_sim;
  end
endmodule
